// ===== ssb_defs.svh
// Register offsets, field positions, reset values and timing counts.
// Assumes inclusion by the package and design files of the status block.
`ifndef SSB_DEFS_SVH
`define SSB_DEFS_SVH

// ****************************************
// Register indices; one word each, byte address is four times the index
// ****************************************
`define SSB_IDX_RBR_THR 12'h3F8
`define SSB_IDX_IER 12'h3F9
`define SSB_IDX_LCR 12'h3FB
`define SSB_IDX_MCR 12'h3FC
`define SSB_IDX_LSR 12'h3FD
`define SSB_IDX_MSR 12'h3FE
`define SSB_IDX_DLL 12'h3F0
`define SSB_IDX_DLM 12'h3F1
`define SSB_IDX_EVT 12'h3F2

// ****************************************
// Register byte addresses
// ****************************************
`define SSB_ADDR_RBR_THR (`SSB_IDX_RBR_THR << 2)
`define SSB_ADDR_IER (`SSB_IDX_IER << 2)
`define SSB_ADDR_LCR (`SSB_IDX_LCR << 2)
`define SSB_ADDR_MCR (`SSB_IDX_MCR << 2)
`define SSB_ADDR_LSR (`SSB_IDX_LSR << 2)
`define SSB_ADDR_MSR (`SSB_IDX_MSR << 2)
`define SSB_ADDR_DLL (`SSB_IDX_DLL << 2)
`define SSB_ADDR_DLM (`SSB_IDX_DLM << 2)
`define SSB_ADDR_EVT (`SSB_IDX_EVT << 2)

// ****************************************
// Field positions
// ****************************************
`define SSB_LSR_DR   0
`define SSB_LSR_OE   1
`define SSB_LSR_PE   2
`define SSB_LSR_FE   3
`define SSB_LSR_BI   4
`define SSB_LSR_HRV  5
`define SSB_LSR_TEMT 6
`define SSB_IER_RDA  0
`define SSB_IER_HRV  1
`define SSB_IER_RLS  2
`define SSB_IER_MS   3
`define SSB_LCR_PEN  3
`define SSB_LCR_EPS  4
`define SSB_LCR_STB  2
`define SSB_MCR_LOOP 4

// ****************************************
// Reset values
// ****************************************
`define SSB_LSR_RESET 8'h60
`define SSB_DIV_RESET 16'h0001

// ****************************************
// Timing: baud input about 1.84 MHz from the 10 MHz clock
// ****************************************
`define SSB_REF_HZ  10000000
`define SSB_BAUD_HZ 1840000
`define SSB_BAUD_ACC_STEP 16'h2F1A

`endif

// ===== ssb_pkg.sv
// Types shared by the status block files.
// Assumes ssb_defs.svh is in the include path.
package ssb_pkg;
`include "ssb_defs.svh"

    typedef struct packed {
        logic cts;
        logic dsr;
        logic ri;
        logic dcd;
    } ssb_modem_t;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
        logic       parity_bad;
        logic       stop_bad;
    } ssb_rx_char_t;
endpackage

// ===== ssb_baud_gen.sv
// Programmable divider making the 16x baud enable.
// Assumes an input clock enable near 1.84 MHz in the same clock domain.
`timescale 1ns/100ps
module ssb_baud_gen
    import ssb_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic src_tick,
    input wire logic reload,
    input wire logic [DIV_W-1:0] divisor,
    // Output
    output logic tick16
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } ssb_bg_st_t;

    ssb_bg_st_t s_reg;
    ssb_bg_st_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.tick = 1'b0;
        if (reload) begin
            // Avoids a long first count after a new divisor
            s_next.cnt = divisor;
        end else if (src_tick) begin
            if (s_reg.cnt <= DIV_W'(1)) begin
                s_next.cnt = divisor;
                s_next.tick = 1'b1;
            end else begin
                s_next.cnt = s_reg.cnt - DIV_W'(1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end

    assign tick16 = s_reg.tick;
endmodule

// ===== ssb_sync3.sv
// Three-stage input synchroniser; a change counts once stages two and three agree.
// Assumes asynchronous inputs; output is held until the last two stages match.
`timescale 1ns/100ps
module ssb_sync3
    import ssb_pkg::*;
#(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } ssb_sy_st_t;

    ssb_sy_st_t s_reg;
    ssb_sy_st_t s_next;

    always_comb begin
        s_next = s_reg;
        s_next.s1 = d;
        s_next.s2 = s_reg.s1;
        s_next.s3 = s_reg.s2;
        for (int i = 0; i < W; i++) begin
            if (s_reg.s2[i] == s_reg.s3[i]) begin
                s_next.q[i] = s_reg.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= {INIT, INIT, INIT, INIT};
        end else begin
            s_reg <= s_next;
        end
    end

    assign q = s_reg.q;
endmodule

// ===== ssb_serial_status.sv
// Line status, modem status, modem control and baud logic of a serial controller.
// Assumes an APB master on REF_CLK and modem pins that are asynchronous to it.
// Functional notes
// - Transmitter empty reads 1 only when holding and shift registers are empty.
// - Holding-vacant sets on move to shifter, clears on holding write.
// - Holding-vacant with its enable set raises the interrupt request.
// - Break flag sets when input stays low beyond one character time.
// - Overrun, parity, framing or break flags raise line-status interrupt.
// - Framing error sets when the sampled stop bit is zero.
// - Parity error sets on bad parity, clears on line status read.
// - Overrun sets when a character lands before the last was read.
// - Data ready sets when a character enters the receive buffer.
// - Modem status bits 7..4 read 1 while inputs are low.
// - In loopback bits 7..4 show out2, out1, terminal-ready, send-request.
// - Change flags set on input change, all clear on modem status read.
// - Bits 0, 1, 3 record any change of clear-to-send, ready, carrier.
// - Bit 2 sets only when ring goes active to inactive.
// - Any change flag set makes a modem status interrupt condition.
// - Baud generator divides about 1.84 MHz by a 16-bit divisor.
// - Baud output runs at sixteen times the bit rate.
// - Two 8-bit latches; writing either reloads the baud counter.
// - Modem control bits 0..3 drive outputs active outside loopback; reset leaves inactive.
// - User output 2 gates the interrupt onto the system line.
// - Modem status interrupt passes only with enable bit 3 set.
// - Line status interrupt passes only with enable bit 2 set.
`timescale 1ns/100ps
module ssb_serial_status
    import ssb_pkg::*;
#(
    parameter int DIV_W = 16
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic SRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Receiver side events
    input wire logic RX_CHAR_VALID,
    input wire logic [7:0] RX_CHAR_DATA,
    input wire logic RX_PARITY_BIT,
    input wire logic RX_STOP_BIT,
    input wire logic RX_LINE,
    // Transmitter side events
    input wire logic TX_SHIFT_EMPTY,
    input wire logic TX_LOAD_SHIFT,
    // Modem pins, active low
    input wire logic CLEAR_TO_SEND_IN_N,
    input wire logic MODEM_READY_IN_N,
    input wire logic PHONE_BELL_IN_N,
    input wire logic CARRIER_DETECT_IN_N,
    output logic TERMINAL_READY_OUT_N,
    output logic SEND_REQUEST_OUT_N,
    output logic USER_OUT1_N,
    output logic USER_OUT2_N,
    // To the shifters and system
    output logic [7:0] TX_HOLD_DATA,
    output logic TX_HOLD_FULL,
    output logic LOOPBACK,
    output logic BAUD_TICK16,
    output logic SYS_IRQ
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] rbr;
        logic [7:0] thr;
        logic hold_full;
        logic [3:0] ier;
        logic [7:0] lcr;
        logic [4:0] mcr;
        logic [7:0] dll;
        logic [7:0] dlm;
        logic dr;
        logic oe;
        logic pe;
        logic fe;
        logic bi;
        logic [3:0] dflag;
        logic [3:0] mprev;
        logic [15:0] brk_cnt;
        logic [15:0] acc;
        logic src_tick;
        logic reload;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic irq;
    } ssb_st_t;

    ssb_st_t s_reg;
    ssb_st_t s_next;

    logic [3:0] pins_n;
    logic tick16;
    logic rx_sync;
    logic [3:0] mstat;
    logic [15:0] char_ticks;
    logic parity_bad;
    logic [16:0] acc_sum;
    logic wr_go;
    logic rd_go;
    logic ms_int;
    logic rls_int;
    logic any_int;

    // ****************************************
    // Input synchronisers
    // ****************************************
    ssb_sync3 #(.W(4), .INIT(4'hF)) u_msync (
        .clk(REF_CLK),
        .rst(SRST),
        .d({CARRIER_DETECT_IN_N, PHONE_BELL_IN_N, MODEM_READY_IN_N, CLEAR_TO_SEND_IN_N}),
        .q(pins_n)
    );

    ssb_sync3 #(.W(1), .INIT(1'b1)) u_rxsync (
        .clk(REF_CLK),
        .rst(SRST),
        .d(RX_LINE),
        .q(rx_sync)
    );

    ssb_baud_gen #(.DIV_W(DIV_W)) u_baud (
        .clk(REF_CLK),
        .rst(SRST),
        .src_tick(s_reg.src_tick),
        .reload(s_reg.reload),
        .divisor({s_reg.dlm, s_reg.dll}),
        .tick16(tick16)
    );

    // ****************************************
    // Combinational helpers
    // ****************************************
    assign acc_sum = {1'b0, s_reg.acc} + {1'b0, 16'(`SSB_BAUD_ACC_STEP)};
    assign wr_go = PSEL && PENABLE && PWRITE && !s_reg.pready;
    assign rd_go = PSEL && PENABLE && !PWRITE && !s_reg.pready;

    // Status order: dcd, ri, dsr, cts in bits 3..0
    always_comb begin
        if (s_reg.mcr[`SSB_MCR_LOOP]) begin
            mstat = {s_reg.mcr[3], s_reg.mcr[2], s_reg.mcr[0], s_reg.mcr[1]};
        end else begin
            mstat = ~pins_n;
        end
    end

    // Ticks of 16x per character: start, data, parity, stop bits
    always_comb begin
        char_ticks = 16'((7 + 32'(s_reg.lcr[1:0]) + 32'(s_reg.lcr[`SSB_LCR_PEN])
                     + 32'(s_reg.lcr[`SSB_LCR_STB])) * 16);
    end

    always_comb begin
        parity_bad = 1'b0;
        if (s_reg.lcr[`SSB_LCR_PEN]) begin
            parity_bad = ((^RX_CHAR_DATA) ^ RX_PARITY_BIT) != !s_reg.lcr[`SSB_LCR_EPS];
        end
    end

    assign ms_int = s_reg.ier[`SSB_IER_MS] && (|s_reg.dflag);
    assign rls_int = s_reg.ier[`SSB_IER_RLS]
                   && (s_reg.oe || s_reg.pe || s_reg.fe || s_reg.bi);
    assign any_int = ms_int || rls_int
                   || (s_reg.ier[`SSB_IER_HRV] && !s_reg.hold_full)
                   || (s_reg.ier[`SSB_IER_RDA] && s_reg.dr);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        s_next = s_reg;
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        s_next.reload = 1'b0;

        // 1.84 MHz enable by phase accumulator
        s_next.acc = acc_sum[15:0];
        s_next.src_tick = acc_sum[16];

        // Clears from the bus first, so hardware sets below win
        if (rd_go) begin
            s_next.pready = 1'b1;
            unique case (PADDR)
                `SSB_ADDR_RBR_THR: s_next.prdata = {24'h0, s_reg.rbr};
                `SSB_ADDR_IER: s_next.prdata = {28'h0, s_reg.ier};
                `SSB_ADDR_LCR: s_next.prdata = {24'h0, s_reg.lcr};
                `SSB_ADDR_MCR: s_next.prdata = {27'h0, s_reg.mcr};
                `SSB_ADDR_LSR: s_next.prdata = {24'h0, 1'b0,
                    !s_reg.hold_full && TX_SHIFT_EMPTY, !s_reg.hold_full,
                    s_reg.bi, s_reg.fe, s_reg.pe, s_reg.oe, s_reg.dr};
                `SSB_ADDR_MSR: s_next.prdata = {24'h0, mstat, s_reg.dflag};
                `SSB_ADDR_DLL: s_next.prdata = {24'h0, s_reg.dll};
                `SSB_ADDR_DLM: s_next.prdata = {24'h0, s_reg.dlm};
                default: begin
                    s_next.prdata = 32'h0;
                    s_next.pslverr = 1'b1;
                end
            endcase
            if (PADDR == `SSB_ADDR_RBR_THR) begin
                s_next.dr = 1'b0;
            end
            if (PADDR == `SSB_ADDR_LSR) begin
                s_next.oe = 1'b0;
                s_next.pe = 1'b0;
                s_next.fe = 1'b0;
                s_next.bi = 1'b0;
            end
            if (PADDR == `SSB_ADDR_MSR) begin
                s_next.dflag = 4'h0;
            end
        end

        if (wr_go) begin
            s_next.pready = 1'b1;
            s_next.prdata = 32'h0;
            unique case (PADDR)
                `SSB_ADDR_RBR_THR: begin
                    s_next.thr = PWDATA[7:0];
                    s_next.hold_full = 1'b1;
                end
                `SSB_ADDR_IER: s_next.ier = PWDATA[3:0];
                `SSB_ADDR_LCR: s_next.lcr = PWDATA[7:0];
                `SSB_ADDR_MCR: s_next.mcr = PWDATA[4:0];
                `SSB_ADDR_DLL: begin
                    s_next.dll = PWDATA[7:0];
                    s_next.reload = 1'b1;
                end
                `SSB_ADDR_DLM: begin
                    s_next.dlm = PWDATA[7:0];
                    s_next.reload = 1'b1;
                end
                // Interrupt test hook: set line and modem flags by hand
                `SSB_ADDR_EVT: begin
                    s_next.oe = s_reg.oe | PWDATA[1];
                    s_next.pe = s_reg.pe | PWDATA[2];
                    s_next.fe = s_reg.fe | PWDATA[3];
                    s_next.bi = s_reg.bi | PWDATA[4];
                    s_next.dflag = s_reg.dflag | PWDATA[11:8];
                end
                `SSB_ADDR_LSR, `SSB_ADDR_MSR: begin
                end
                default: s_next.pslverr = 1'b1;
            endcase
        end

        // Transmit path
        if (TX_LOAD_SHIFT && s_reg.hold_full) begin
            s_next.hold_full = 1'b0;
        end

        // Receive path
        if (RX_CHAR_VALID) begin
            s_next.rbr = RX_CHAR_DATA;
            s_next.dr = 1'b1;
            if (s_reg.dr) begin
                s_next.oe = 1'b1;
            end
            if (parity_bad) begin
                s_next.pe = 1'b1;
            end
            if (!RX_STOP_BIT) begin
                s_next.fe = 1'b1;
            end
        end

        // Break: count 16x ticks while the line is spacing
        if (rx_sync) begin
            s_next.brk_cnt = 16'h0;
        end else if (tick16) begin
            if (s_reg.brk_cnt > char_ticks) begin
                s_next.bi = 1'b1;
            end else begin
                s_next.brk_cnt = s_reg.brk_cnt + 16'h1;
            end
        end

        // Modem change detect; loopback sources count too
        s_next.mprev = mstat;
        if (mstat[0] != s_reg.mprev[0]) s_next.dflag[0] = 1'b1;
        if (mstat[1] != s_reg.mprev[1]) s_next.dflag[1] = 1'b1;
        if (mstat[3] != s_reg.mprev[3]) s_next.dflag[3] = 1'b1;
        if (!mstat[2] && s_reg.mprev[2]) s_next.dflag[2] = 1'b1;

        s_next.irq = any_int && s_reg.mcr[3];
    end

    // ****************************************
    // Registers
    // ****************************************
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            s_reg <= '0;
            s_reg.dll <= 8'(`SSB_DIV_RESET);
        end else begin
            s_reg <= s_next;
        end
    end

    // Output stage; loopback forces modem outputs inactive
    typedef struct packed {
        logic [3:0] mout_n;
        logic tick;
    } ssb_out_t;

    ssb_out_t o_reg;

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            o_reg <= '1;
            o_reg.tick <= 1'b0;
        end else begin
            o_reg.mout_n <= s_next.mcr[4] ? 4'hF : ~s_next.mcr[3:0];
            o_reg.tick <= tick16;
        end
    end

    assign TERMINAL_READY_OUT_N = o_reg.mout_n[0];
    assign SEND_REQUEST_OUT_N = o_reg.mout_n[1];
    assign USER_OUT1_N = o_reg.mout_n[2];
    assign USER_OUT2_N = o_reg.mout_n[3];
    assign BAUD_TICK16 = o_reg.tick;
    assign PRDATA = s_reg.prdata;
    assign PREADY = s_reg.pready;
    assign PSLVERR = s_reg.pslverr;
    assign TX_HOLD_DATA = s_reg.thr;
    assign TX_HOLD_FULL = s_reg.hold_full;
    assign LOOPBACK = s_reg.mcr[4];
    assign SYS_IRQ = s_reg.irq;
endmodule

// ===== ssb_modem_model.sv
// Stand-in for the modem: drives the four status lines.
// Assumes the bench sets the wanted levels; lines move just after REF_CLK.
`timescale 1ns/100ps
module ssb_modem_model
    import ssb_pkg::*;
(
    // Clock and wanted levels
    input wire logic clk,
    input wire logic [3:0] want,
    // Carrier, bell, ready, clear; active low
    output logic [3:0] lines_n
);
    // Lines follow the wanted levels one edge later
    always @(posedge clk) begin
        lines_n <= want;
    end
endmodule

// ===== ssb_serial_status_chk.sv
// Concurrent checks on the ports of the status block.
// Assumes a bind onto ssb_serial_status; one clock, synchronous reset.
`timescale 1ns/100ps
`include "ssb_defs.svh"
module ssb_serial_status_chk
    import ssb_pkg::*;
(
    // Clock, reset and bus
    input wire logic REF_CLK,
    input wire logic SRST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PRDATA,
    input wire logic PREADY,
    input wire logic PSLVERR,
    // Transmit, modem and system
    input wire logic TX_LOAD_SHIFT,
    input wire logic TX_HOLD_FULL,
    input wire logic CLEAR_TO_SEND_IN_N,
    input wire logic MODEM_READY_IN_N,
    input wire logic PHONE_BELL_IN_N,
    input wire logic CARRIER_DETECT_IN_N,
    input wire logic TERMINAL_READY_OUT_N,
    input wire logic SEND_REQUEST_OUT_N,
    input wire logic USER_OUT1_N,
    input wire logic USER_OUT2_N,
    input wire logic LOOPBACK,
    input wire logic BAUD_TICK16,
    input wire logic SYS_IRQ
);
    logic [3:0] pins_n;
    logic [3:0] pins_q;
    logic [3:0] outs_n;
    logic [3:0] calm_cnt;
    assign pins_n = {CARRIER_DETECT_IN_N, PHONE_BELL_IN_N, MODEM_READY_IN_N, CLEAR_TO_SEND_IN_N};
    assign outs_n = {USER_OUT2_N, USER_OUT1_N, SEND_REQUEST_OUT_N, TERMINAL_READY_OUT_N};
    // Pins must settle past the synchronisers before status may follow them
    always_ff @(posedge REF_CLK) begin
        pins_q <= pins_n;
        if (SRST || LOOPBACK || pins_n != pins_q)
            calm_cnt <= 4'h0;
        else if (calm_cnt != 4'hF)
            calm_cnt <= calm_cnt + 4'h1;
    end
    // ****************************************
    // Assertions
    // ****************************************
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    sequence acc_s;
        PSEL && PENABLE && PREADY;
    endsequence
    sequence thr_wr_s;
        acc_s ##0 (PWRITE && PADDR == `SSB_ADDR_RBR_THR);
    endsequence
    sequence msr_rd_s;
        acc_s ##0 (!PWRITE && PADDR == `SSB_ADDR_MSR);
    endsequence
    ready_wait_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("access not answered after one wait");
    ready_pulse_a: assert property (PREADY |=> !PREADY)
        else $error("ready held too long");
    err_ready_a: assert property (PSLVERR |-> PREADY)
        else $error("error without ready");
    rst_out_a: assert property ($past(SRST) |-> outs_n == 4'hF && !SYS_IRQ)
        else $error("outputs active after reset");
    irq_gate_a: assert property (USER_OUT2_N && $past(USER_OUT2_N) && $past(USER_OUT2_N, 2)
        && !LOOPBACK && !$past(LOOPBACK) && !$past(LOOPBACK, 2) |-> !SYS_IRQ)
        else $error("interrupt passed with out2 inactive");
    loop_quiet_a: assert property (LOOPBACK && $past(LOOPBACK) |-> outs_n == 4'hF)
        else $error("modem outputs active in loopback");
    hold_set_a: assert property (thr_wr_s |-> ##[0:1] TX_HOLD_FULL)
        else $error("holding write left register vacant");
    hold_clr_a: assert property (TX_LOAD_SHIFT && !PSEL |=> !TX_HOLD_FULL)
        else $error("holding register still full after move");
    tick_gap_a: assert property (BAUD_TICK16 |=> !BAUD_TICK16 [*3])
        else $error("baud ticks too close");
    msr_pins_a: assert property (msr_rd_s ##0 calm_cnt == 4'hF |-> PRDATA[7:4] == ~pins_n)
        else $error("modem status not matching pins");
endmodule

// ===== ssb_serial_status_tb.sv
// Self-checking bench for the status block.
// Assumes the design, checker and modem model files compile before it.
`timescale 1ns/100ps
`include "ssb_defs.svh"
module testbench;
    import ssb_pkg::*;
    logic REF_CLK = 1'b0, SRST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
    logic [11:0] PADDR = 12'h000;
    logic [31:0] PWDATA = 32'h0, PRDATA, rd;
    logic PREADY, PSLVERR, err, LOOPBACK, BAUD_TICK16, SYS_IRQ, TX_HOLD_FULL;
    logic RX_CHAR_VALID = 1'b0, RX_PARITY_BIT = 1'b0, RX_STOP_BIT = 1'b1, RX_LINE = 1'b1;
    logic [7:0] RX_CHAR_DATA = 8'h00, TX_HOLD_DATA;
    logic TX_SHIFT_EMPTY = 1'b1, TX_LOAD_SHIFT = 1'b0;
    logic CLEAR_TO_SEND_IN_N, MODEM_READY_IN_N, PHONE_BELL_IN_N, CARRIER_DETECT_IN_N;
    logic TERMINAL_READY_OUT_N, SEND_REQUEST_OUT_N, USER_OUT1_N, USER_OUT2_N;
    logic [3:0] want = 4'hF, lines_n;
    wire [4:0] outs = {LOOPBACK, USER_OUT2_N, USER_OUT1_N, SEND_REQUEST_OUT_N, TERMINAL_READY_OUT_N};
    int error_cnt = 0;
    int comparisons = 0;
    int k;
    assign {CARRIER_DETECT_IN_N, PHONE_BELL_IN_N, MODEM_READY_IN_N, CLEAR_TO_SEND_IN_N} = lines_n;
    ssb_serial_status dut_u (.*);
    ssb_modem_model modem_u (.clk(REF_CLK), .want(want), .lines_n(lines_n));
    initial begin
        forever #50 REF_CLK = ~REF_CLK;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // Tick counts drift by one with accumulator phase
    task automatic near(input int e, input int g);
        chk(e, (g >= e - 1 && g <= e + 1) ? e : g);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge REF_CLK);
    endtask
    // Entered just after an edge; request held until ready is sampled
    task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        PSEL <= 1'b1;
        PWRITE <= wr;
        PADDR <= a;
        PWDATA <= {24'h0, d};
        @(posedge REF_CLK);
        PENABLE <= 1'b1;
        do begin
            @(posedge REF_CLK);
            n++;
        end while (PREADY !== 1'b1 && n < 50);
        rd = PRDATA;
        err = PSLVERR;
        PSEL <= 1'b0;
        PENABLE <= 1'b0;
        // Idle edge so a following call never drives PSEL twice at once
        @(posedge REF_CLK);
        if (n == 50) begin
            error_cnt++;
            stop_test();
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk({24'h0, e}, rd);
    endtask
    task automatic irq(input logic e);
        cyc(3);
        chk({31'h0, e}, {31'h0, SYS_IRQ});
    endtask
    task automatic rx(input logic [7:0] d, input logic p, input logic s);
        RX_CHAR_VALID <= 1'b1;
        RX_CHAR_DATA <= d;
        RX_PARITY_BIT <= p;
        RX_STOP_BIT <= s;
        @(posedge REF_CLK);
        RX_CHAR_VALID <= 1'b0;
        @(posedge REF_CLK);
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset();
        rchk(`SSB_ADDR_LSR, 8'h60);
        rchk(`SSB_ADDR_MCR, 8'h00);
        chk(32'h0F, {27'h0, outs});
        apb(1'b0, 12'h3F0, 8'h00);
        chk(32'h1, {31'h0, err});
        $display("reset test done");
    endtask
    task automatic t_tx();
        apb(1'b1, `SSB_ADDR_IER, 8'h02);
        apb(1'b1, `SSB_ADDR_RBR_THR, 8'hA5);
        rchk(`SSB_ADDR_LSR, 8'h00);
        chk(32'hA5, {24'h0, TX_HOLD_DATA});
        apb(1'b1, `SSB_ADDR_MCR, 8'h08);
        irq(1'b0);
        TX_LOAD_SHIFT <= 1'b1;
        TX_SHIFT_EMPTY <= 1'b0;
        @(posedge REF_CLK);
        TX_LOAD_SHIFT <= 1'b0;
        rchk(`SSB_ADDR_LSR, 8'h20);
        irq(1'b1);
        apb(1'b1, `SSB_ADDR_MCR, 8'h00);
        irq(1'b0);
        TX_SHIFT_EMPTY <= 1'b1;
        rchk(`SSB_ADDR_LSR, 8'h60);
        apb(1'b1, `SSB_ADDR_IER, 8'h00);
        $display("transmit test done");
    endtask
    task automatic t_rx();
        apb(1'b1, `SSB_ADDR_LCR, 8'h1B);
        apb(1'b1, `SSB_ADDR_IER, 8'h04);
        apb(1'b1, `SSB_ADDR_MCR, 8'h08);
        rx(8'h01, 1'b0, 1'b0);
        irq(1'b1);
        rchk(`SSB_ADDR_LSR, 8'h6D);
        irq(1'b0);
        rx(8'h03, 1'b0, 1'b1);
        rchk(`SSB_ADDR_LSR, 8'h63);
        rchk(`SSB_ADDR_LSR, 8'h61);
        rchk(`SSB_ADDR_RBR_THR, 8'h03);
        rchk(`SSB_ADDR_LSR, 8'h60);
        apb(1'b1, `SSB_ADDR_LCR, 8'h0B);
        rx(8'h01, 1'b1, 1'b1);
        rchk(`SSB_ADDR_LSR, 8'h65);
        rchk(`SSB_ADDR_RBR_THR, 8'h01);
        apb(1'b1, `SSB_ADDR_IER, 8'h00);
        $display("receive test done");
    endtask
    // Eleven bits at divisor one take about 957 cycles
    task automatic t_break();
        RX_LINE <= 1'b0;
        cyc(700);
        apb(1'b0, `SSB_ADDR_LSR, 8'h00);
        chk(32'h0, rd & 32'h10);
        cyc(600);
        rchk(`SSB_ADDR_LSR, 8'h70);
        RX_LINE <= 1'b1;
        $display("break test done");
    endtask
    task automatic t_modem();
        logic [3:0] pin_tab [5] = '{4'hE, 4'hE, 4'hA, 4'hE, 4'h4};
        logic [7:0] msr_tab [5] = '{8'h11, 8'h10, 8'h50, 8'h14, 8'hBA};
        apb(1'b1, `SSB_ADDR_IER, 8'h08);
        apb(1'b1, `SSB_ADDR_MCR, 8'h08);
        for (int i = 0; i < 5; i++) begin
            want <= pin_tab[i];
            cyc(20);
            chk({31'h0, |msr_tab[i][3:0]}, {31'h0, SYS_IRQ});
            rchk(`SSB_ADDR_MSR, msr_tab[i]);
        end
        apb(1'b1, `SSB_ADDR_IER, 8'h00);
        want <= 4'hF;
        irq(1'b0);
        cyc(20);
        rchk(`SSB_ADDR_MSR, 8'h0B);
        $display("modem test done");
    endtask
    task automatic t_loop();
        apb(1'b1, `SSB_ADDR_MCR, 8'h15);
        cyc(10);
        apb(1'b0, `SSB_ADDR_MSR, 8'h00);
        chk(32'h60, rd & 32'hF0);
        chk(32'h1F, {27'h0, outs});
        apb(1'b1, `SSB_ADDR_MCR, 8'h1A);
        cyc(10);
        apb(1'b0, `SSB_ADDR_MSR, 8'h00);
        chk(32'h90, rd & 32'hF0);
        apb(1'b1, `SSB_ADDR_MCR, 8'h0F);
        cyc(2);
        chk(32'h00, {27'h0, outs});
        apb(1'b1, `SSB_ADDR_MCR, 8'h00);
        $display("loopback test done");
    endtask
    task automatic cnt(input int n);
        k = 0;
        repeat (n) begin
            @(posedge REF_CLK);
            k += (BAUD_TICK16 === 1'b1);
        end
    endtask
    // Input rate is 12058/65536 of REF_CLK
    task automatic t_baud();
        cnt(2000);
        near(2000 * 12058 / 65536, k);
        apb(1'b1, `SSB_ADDR_DLL, 8'h03);
        cnt(2000);
        near(2000 * 12058 / 65536 / 3, k);
        apb(1'b1, `SSB_ADDR_DLM, 8'h01);
        cyc(100);
        apb(1'b1, `SSB_ADDR_DLM, 8'h00);
        cnt(40);
        near(2, k);
        $display("baud test done");
    endtask
    initial begin
        repeat (6) @(posedge REF_CLK);
        SRST <= 1'b0;
        @(posedge REF_CLK);
        t_reset();
        t_tx();
        t_rx();
        t_break();
        t_modem();
        t_loop();
        t_baud();
        stop_test();
    end
endmodule
bind ssb_serial_status ssb_serial_status_chk chk_u (.*);
